// File: logic/ccs_map.svh
`ifndef CCS_MAP_SVH
`define CCS_MAP_SVH

// Register byte offsets
`define CCS_ADDR_W 8
`define CCS_OFS_CTRL 8'h00
`define CCS_OFS_STATE 8'h04
`define CCS_OFS_INT_STAT 8'h08
`define CCS_OFS_INT_CLR 8'h0c
`define CCS_OFS_INT_EN 8'h10

// Control word layout
`define CCS_CTRL_RESET 16'h0000
`define CCS_CTRL_WMASK 16'hbfdf
`define CCS_OUTPUT_ENABLE_SYNC_BIT 15
`define CCS_STEER_HI 13
`define CCS_STEER_LO 8
`define CCS_GATE_HI 7
`define CCS_GATE_LO 6
`define CCS_AUX_HI 4
`define CCS_AUX_LO 3
`define CCS_CAPSEL_HI 2
`define CCS_CAPSEL_LO 0

// Capture gate modes
`define CCS_GM_LEVEL 2'h0
`define CCS_GM_ONESHOT_EN 2'h1
`define CCS_GM_ONESHOT_DIS 2'h2

// Auxiliary output select codes
`define CCS_AUX_OFF 2'h0
`define CCS_AUX_ROLL 2'h1
`define CCS_AUX_MODE 2'h2
`define CCS_AUX_EVENT 2'h3

// Capture source select codes
`define CCS_CAP_PIN 3'h0
`define CCS_CAP_CMP1 3'h1
`define CCS_CAP_CMP2 3'h2
`define CCS_CAP_CMP3 3'h3
`define CCS_CAP_LC1 3'h5
`define CCS_CAP_LC2 3'h6

// Interrupt status bits
`define CCS_INT_W 3
`define CCS_INT_CAPTURE 0
`define CCS_INT_DISABLE 1
`define CCS_INT_ROLL 2

// Synchroniser input layout: 8 gate sources, logic cell two, capture pin
`define CCS_SYNC_W 10
`define CCS_SYNC_LC2 8
`define CCS_SYNC_PIN 9

// Pin release state and gate enable field of the state register
`define CCS_PINS_RELEASED 6'h3f
`define CCS_GATE_EN_HI 15
`define CCS_GATE_EN_LO 8

`endif

// File: logic/ccs_pkg.sv
`include "ccs_map.svh"

package ccs_pkg;

    typedef struct packed {
        logic output_enable_sync;
        logic [5:0] pin_steer_enables;
        logic [1:0] capture_gate_mode;
        logic [1:0] aux_output_select;
        logic [2:0] capture_source_select;
    } ccs_ctrl_t;

    // Bit 0 is comparator 1, bit 7 is fault input B
    typedef struct packed {
        logic fault_input_b;
        logic fault_input_a;
        logic logic_cell_one;
        logic cap5_compare;
        logic cap4_compare;
        logic cmp3;
        logic cmp2;
        logic cmp1;
    } ccs_src_t;

    typedef struct packed {
        logic [`CCS_ADDR_W-1:0] addr;
        logic [15:0] wdata;
        logic we;
        logic re;
    } ccs_bus_req_t;

endpackage

// File: logic/ccs_sync.sv
module ccs_sync #(
    parameter int WIDTH = 10
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // Asynchronous levels in, filtered levels out
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] stable_o
);

    // Value accepted only once the second and third stages agree
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        logic s1_q;
        logic s2_q;
        logic s3_q;
        logic out_q;
        always_ff @(posedge sys_clk_i or posedge rst_i) begin
            if (rst_i) begin
                s1_q <= 1'b0;
                s2_q <= 1'b0;
                s3_q <= 1'b0;
                out_q <= 1'b0;
            end else begin
                s1_q <= async_i[i];
                s2_q <= s1_q;
                s3_q <= s2_q;
                if (s2_q == s3_q) begin
                    out_q <= s3_q;
                end
            end
        end
        assign stable_o[i] = out_q;
    end

endmodule // ccs_sync

// File: logic/ccs_ctrl.sv
// Implementation choices: the plain strobed port and the register offsets.
`include "ccs_map.svh"

// Operation
// - Gate enable bits 0-7: comparators 1-3, capture 4/5 compare, logic cell 1, faults A/B.
// - Each set steering bit drives its pin with the compare or PWM signal.
// - Each clear steering bit releases its pin to port logic.
// - Gate mode 10: gating source falling edge sets capture disable flag.
// - Gate mode 01: gating source rising edge clears capture disable flag.
// - Gate mode 00: capture allowed while gating source high, blocked while low.
// - Aux select: 00 off, 01 rollover, 10 mode signal, 11 capture/compare events.
// - Capture select 010 comparator 2, 011 comparator 3, 110 logic cell 2; 111 unused.
module ccs_ctrl (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // Register port
    input wire logic [`CCS_ADDR_W-1:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_we_i,
    input wire logic reg_re_i,
    output logic [15:0] reg_rdata_o,
    // Asynchronous sources
    input wire ccs_pkg::ccs_src_t gate_src_i,
    input wire logic logic_cell_two_i,
    input wire logic capture_pin_i,
    // Time base and engine signals
    input wire logic tb_reset_i,
    input wire logic tb_rollover_i,
    input wire logic pwm_i,
    input wire logic mode_signal_i,
    input wire logic compare_event_i,
    // Output pins
    output logic [5:0] compare_output_pin_o,
    output logic [5:0] compare_output_pin_oe_n_o,
    // Gating and capture
    output logic shutdown_gate_o,
    output logic capture_disable_flag_o,
    output logic capture_src_o,
    output logic capture_event_o,
    output logic aux_o,
    // Interrupt
    output logic irq_o
);

    ccs_pkg::ccs_ctrl_t ctrl_q;
    ccs_pkg::ccs_bus_req_t req;
    logic [`CCS_SYNC_W-1:0] stable;
    logic [7:0] src_s;
    logic [5:0] steer_act_q;
    logic [5:0] pin_q;
    logic [5:0] oe_n_q;
    logic gate_q;
    logic gate_prev_q;
    logic dis_q;
    logic cap_q;
    logic cap_prev_q;
    logic cap_evt_q;
    logic aux_q;
    logic [7:0] shutdown_en_q;
    logic [`CCS_INT_W-1:0] int_stat_q;
    logic [`CCS_INT_W-1:0] int_en_q;
    logic [`CCS_INT_W-1:0] int_evt;
    logic [15:0] rdata_q;
    logic [15:0] ctrl_rd;
    logic cap_mux;
    logic tb_evt;
    logic gate_rise;
    logic gate_fall;
    logic cap_rise;

    assign req = '{addr: reg_addr_i, wdata: reg_wdata_i, we: reg_we_i, re: reg_re_i};

    ccs_sync #(
        .WIDTH(`CCS_SYNC_W)
    ) u_sync (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .async_i({capture_pin_i, logic_cell_two_i, gate_src_i}),
        .stable_o(stable)
    );

    assign src_s = stable[7:0];
    assign tb_evt = tb_reset_i | tb_rollover_i;
    assign gate_rise = gate_q & ~gate_prev_q;
    assign gate_fall = ~gate_q & gate_prev_q;
    assign cap_rise = cap_q & ~cap_prev_q;

    // reset to zero, reserved bits held at zero
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_q <= ccs_pkg::ccs_ctrl_t'($bits(ccs_pkg::ccs_ctrl_t)'(`CCS_CTRL_RESET));
        end else if (req.we && req.addr == `CCS_OFS_CTRL) begin
            ctrl_q.output_enable_sync <= req.wdata[`CCS_OUTPUT_ENABLE_SYNC_BIT];
            ctrl_q.pin_steer_enables <= req.wdata[`CCS_STEER_HI:`CCS_STEER_LO];
            ctrl_q.capture_gate_mode <= req.wdata[`CCS_GATE_HI:`CCS_GATE_LO];
            ctrl_q.aux_output_select <= req.wdata[`CCS_AUX_HI:`CCS_AUX_LO];
            ctrl_q.capture_source_select <= req.wdata[`CCS_CAPSEL_HI:`CCS_CAPSEL_LO];
        end
    end

    assign ctrl_rd = {ctrl_q.output_enable_sync, 1'b0, ctrl_q.pin_steer_enables,
                      ctrl_q.capture_gate_mode, 1'b0, ctrl_q.aux_output_select,
                      ctrl_q.capture_source_select};

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            steer_act_q <= 6'h00;
        end else if (!ctrl_q.output_enable_sync || tb_evt) begin
            steer_act_q <= ctrl_q.pin_steer_enables;
        end
    end

    // steered pins carry the PWM signal
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pin_q <= 6'h00;
            oe_n_q <= `CCS_PINS_RELEASED;
        end else begin
            pin_q <= steer_act_q & {6{pwm_i}};
            oe_n_q <= ~steer_act_q;
        end
    end

    // gating source is OR of enabled sources
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            gate_q <= 1'b0;
            gate_prev_q <= 1'b0;
        end else begin
            gate_q <= |(src_s & shutdown_en_q);
            gate_prev_q <= gate_q;
        end
    end

    // Gate enables live in the upper half of the state register
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            shutdown_en_q <= 8'h00;
        end else if (req.we && req.addr == `CCS_OFS_STATE) begin
            shutdown_en_q <= req.wdata[`CCS_GATE_EN_HI:`CCS_GATE_EN_LO];
        end
    end

    // Capture disable flag per gate mode; reserved mode holds
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            dis_q <= 1'b0;
        end else begin
            unique case (ctrl_q.capture_gate_mode)
                `CCS_GM_LEVEL: dis_q <= ~gate_q;
                `CCS_GM_ONESHOT_EN: if (gate_rise) begin
                    dis_q <= 1'b0;
                end
                `CCS_GM_ONESHOT_DIS: if (gate_fall) begin
                    dis_q <= 1'b1;
                end
                default: dis_q <= dis_q;
            endcase
        end
    end

    always_comb begin
        unique case (ctrl_q.capture_source_select)
            `CCS_CAP_PIN: cap_mux = stable[`CCS_SYNC_PIN];
            `CCS_CAP_CMP1: cap_mux = src_s[0];
            `CCS_CAP_CMP2: cap_mux = src_s[1];
            `CCS_CAP_CMP3: cap_mux = src_s[2];
            `CCS_CAP_LC1: cap_mux = src_s[5];
            `CCS_CAP_LC2: cap_mux = stable[`CCS_SYNC_LC2];
            default: cap_mux = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cap_q <= 1'b0;
            cap_prev_q <= 1'b0;
            cap_evt_q <= 1'b0;
        end else begin
            cap_q <= cap_mux;
            cap_prev_q <= cap_q;
            cap_evt_q <= cap_rise & ~dis_q;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            aux_q <= 1'b0;
        end else begin
            unique case (ctrl_q.aux_output_select)
                `CCS_AUX_OFF: aux_q <= 1'b0;
                `CCS_AUX_ROLL: aux_q <= tb_rollover_i;
                `CCS_AUX_MODE: aux_q <= mode_signal_i;
                `CCS_AUX_EVENT: aux_q <= cap_evt_q | compare_event_i;
            endcase
        end
    end

    // Sticky status; a new event wins over a clear in the same cycle
    assign int_evt = {tb_rollover_i, gate_fall & ~dis_q &
                      (ctrl_q.capture_gate_mode == `CCS_GM_ONESHOT_DIS), cap_evt_q};
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            int_stat_q <= '0;
            int_en_q <= '0;
        end else begin
            if (req.we && req.addr == `CCS_OFS_INT_EN) begin
                int_en_q <= req.wdata[`CCS_INT_W-1:0];
            end
            if (req.we && req.addr == `CCS_OFS_INT_CLR) begin
                int_stat_q <= (int_stat_q & ~req.wdata[`CCS_INT_W-1:0]) | int_evt;
            end else begin
                int_stat_q <= int_stat_q | int_evt;
            end
        end
    end

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_q <= 16'h0000;
        end else if (req.re) begin
            unique case (req.addr)
                `CCS_OFS_CTRL: rdata_q <= ctrl_rd;
                `CCS_OFS_STATE: rdata_q <= {shutdown_en_q, 2'h0, steer_act_q[5:0] & 6'h3f};
                `CCS_OFS_INT_STAT: rdata_q <= {13'h0000, int_stat_q};
                `CCS_OFS_INT_EN: rdata_q <= {13'h0000, int_en_q};
                default: rdata_q <= 16'h0000;
            endcase
        end else begin
            rdata_q <= 16'h0000;
        end
    end

    assign reg_rdata_o = rdata_q;
    assign compare_output_pin_o = pin_q;
    assign compare_output_pin_oe_n_o = oe_n_q;
    assign shutdown_gate_o = gate_q;
    assign capture_disable_flag_o = dis_q;
    assign capture_src_o = cap_q;
    assign capture_event_o = cap_evt_q;
    assign aux_o = aux_q;
    assign irq_o = |(int_stat_q & int_en_q);

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    sequence s_fall_oneshot;
        ctrl_q.capture_gate_mode == `CCS_GM_ONESHOT_DIS && gate_fall;
    endsequence
    sequence s_rise_oneshot;
        ctrl_q.capture_gate_mode == `CCS_GM_ONESHOT_EN && gate_rise;
    endsequence

    gate_source_a: assert property ($past(rst_i) == 1'b0 |->
        gate_q == |($past(src_s) & $past(shutdown_en_q)))
        else $error("gating level does not match enabled sources");
    steer_hold_a: assert property (ctrl_q.output_enable_sync && !tb_evt |=> $stable(steer_act_q))
        else $error("steering changed without time base event");
    steer_now_a: assert property (!ctrl_q.output_enable_sync |=> steer_act_q == $past(ctrl_q.pin_steer_enables))
        else $error("steering not applied at once");
    pin_drive_a: assert property (##1 pin_q == ($past(steer_act_q) & {6{$past(pwm_i)}}))
        else $error("pin does not follow pwm signal");
    pin_release_a: assert property (##1 oe_n_q == ~$past(steer_act_q))
        else $error("pin release mismatch");
    oneshot_dis_a: assert property (s_fall_oneshot |=> dis_q ##1 $past(dis_q))
        else $error("falling edge did not disable capture");
    oneshot_en_a: assert property (s_rise_oneshot |=> !dis_q)
        else $error("rising edge did not enable capture");
    level_gate_a: assert property (!rst_i && ctrl_q.capture_gate_mode == `CCS_GM_LEVEL |=>
        dis_q == !$past(gate_q))
        else $error("level gating mismatch");
    blocked_cap_a: assert property (dis_q |=> !cap_evt_q)
        else $error("capture taken while disabled");
    aux_roll_a: assert property (ctrl_q.aux_output_select == `CCS_AUX_ROLL |=>
        aux_q == $past(tb_rollover_i))
        else $error("aux rollover mismatch");
    cap_sel_a: assert property (ctrl_q.capture_source_select == `CCS_CAP_CMP2 |=>
        cap_q == $past(src_s[1]))
        else $error("capture source not comparator 2");
    rsvd_zero_a: assert property (req.re && req.addr == `CCS_OFS_CTRL |=>
        (reg_rdata_o & ~`CCS_CTRL_WMASK) == 16'h0000)
        else $error("reserved bits read nonzero");

endmodule // ccs_ctrl

// File: sim/ccs_pad_model.sv
module ccs_pad_model (
    // Pin side of the block
    input wire logic [5:0] pin_i,
    input wire logic [5:0] pin_oe_n_i,
    // Port logic level for released pads
    input wire logic [5:0] port_i,
    output logic [5:0] pad_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // pad resolution
    // Released pads follow port logic, never the stale compare level
    assign pad_o = (pin_i & ~pin_oe_n_i) | (port_i & pin_oe_n_i);
endmodule // ccs_pad_model

// File: sim/test_ccp_output_steer_gate_ctrl.sv
`include "ccs_map.svh"
module test_ccp_output_steer_gate_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] reg_addr_i = 8'h00;
    logic [15:0] reg_wdata_i = 16'h0000;
    logic reg_we_i = 1'b0;
    logic reg_re_i = 1'b0;
    logic [15:0] reg_rdata_o;
    ccs_pkg::ccs_src_t gate_src_i = 8'h00;
    logic logic_cell_two_i = 1'b0, capture_pin_i = 1'b0, tb_reset_i = 1'b0;
    logic tb_rollover_i = 1'b0, pwm_i = 1'b0, mode_signal_i = 1'b0, compare_event_i = 1'b0;
    logic [5:0] compare_output_pin_o, compare_output_pin_oe_n_o, pad;
    logic shutdown_gate_o, capture_disable_flag_o, capture_src_o, capture_event_o, aux_o, irq_o;
    int err_count = 0, n_checks = 0, ev_n = 0, aux_n = 0, n0;
    int aux_e[4] = '{0, 1, 2, 1};
    logic [2:0] cs[4] = '{3'h2, 3'h3, 3'h6, 3'h7};
    logic [31:0] rnd = 32'h90c7;
    logic [15:0] ctrl_m = 16'h0000;
    logic [7:0] en_m = 8'h00;
    logic [5:0] steer_m = 6'h00;

    always #25 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) begin
        ev_n <= ev_n + int'(capture_event_o === 1'b1);
        aux_n <= aux_n + int'(aux_o === 1'b1);
    end

    ccs_ctrl uut (.sys_clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_we_i, .reg_re_i,
        .reg_rdata_o, .gate_src_i, .logic_cell_two_i, .capture_pin_i, .tb_reset_i,
        .tb_rollover_i, .pwm_i, .mode_signal_i, .compare_event_i, .compare_output_pin_o,
        .compare_output_pin_oe_n_o, .shutdown_gate_o, .capture_disable_flag_o,
        .capture_src_o, .capture_event_o, .aux_o, .irq_o);
    ccs_pad_model pads (.pin_i(compare_output_pin_o), .pin_oe_n_i(compare_output_pin_oe_n_o),
        .port_i(~{6{pwm_i}}), .pad_o(pad));

    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge sys_clk_i);
        reg_we_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= v;
        @(posedge sys_clk_i);
        reg_we_i <= 1'b0;
        if (a == `CCS_OFS_CTRL) ctrl_m = v & `CCS_CTRL_WMASK;
        if (a == `CCS_OFS_CTRL && !v[15]) steer_m = v[13:8];
        #1;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [15:0] exp, input string nm);
        @(posedge sys_clk_i);
        reg_re_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge sys_clk_i);
        reg_re_i <= 1'b0;
        #1;
        chk(nm, reg_rdata_o, exp);
    endtask
    task automatic pins;
        logic [5:0] e;
        logic [5:0] o;
        e = pwm_i ? steer_m : ~steer_m;
        o = ~steer_m;
        chk("pin", compare_output_pin_o, pwm_i ? steer_m : 6'h00);
        chk("oe_n", compare_output_pin_oe_n_o, o);
        chk("pad", pad, e);
    endtask
    task automatic pulse(input int k);
        @(posedge sys_clk_i);
        tb_rollover_i <= (k == 0);
        tb_reset_i <= (k != 0);
        @(posedge sys_clk_i);
        tb_rollover_i <= 1'b0;
        tb_reset_i <= 1'b0;
        if (ctrl_m[15]) steer_m = ctrl_m[13:8];
    endtask
    task automatic src(input logic [7:0] v);
        @(posedge sys_clk_i) gate_src_i <= v;
        tick(6);
    endtask
    task automatic capt(input int exp);
        n0 = ev_n;
        @(posedge sys_clk_i) capture_pin_i <= 1'b1;
        tick(8);
        @(posedge sys_clk_i) capture_pin_i <= 1'b0;
        tick(6);
        chk("capture events", 16'(ev_n - n0), 16'(exp));
    endtask
    task automatic conclude;
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        #(50 * 8000);
        err_count++;
        conclude;
    end

    initial begin
        repeat (6) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        tick(1);
        chk("oe_n reset", compare_output_pin_oe_n_o, 16'h003f);
        rdchk(`CCS_OFS_CTRL, 16'h0000, "ctrl reset");
        rdchk(`CCS_OFS_STATE, 16'h0000, "state reset");
        wr(`CCS_OFS_CTRL, 16'hc0ff);
        rdchk(`CCS_OFS_CTRL, ctrl_m, "ctrl mask");
        wr(8'h20, 16'hffff);
        rdchk(8'h20, 16'h0000, "unmapped");
        rdchk(`CCS_OFS_INT_CLR, 16'h0000, "clear reg");
        wr(`CCS_OFS_CTRL, 16'h0000);
        @(posedge sys_clk_i) pwm_i <= 1'b1;
        repeat (3) begin
            rnd = lfsr(rnd);
            wr(`CCS_OFS_CTRL, {2'b00, rnd[5:0], 8'h00});
            tick(2);
            pins();
        end
        for (int k = 0; k < 2; k++) begin
            rnd = lfsr(rnd);
            wr(`CCS_OFS_CTRL, {2'b10, steer_m ^ (rnd[5:0] | 6'h01), 8'h00});
            tick(3);
            pins();
            pulse(k);
            tick(2);
            pins();
            rdchk(`CCS_OFS_STATE, {en_m, 2'b00, steer_m}, "applied steer");
        end
        wr(`CCS_OFS_CTRL, 16'h0000);
        @(posedge sys_clk_i) pwm_i <= 1'b0;
        tick(2);
        pins();
        for (int i = 0; i < 8; i++) begin
            en_m = 8'h01 << i;
            wr(`CCS_OFS_STATE, {en_m, 8'h00});
            src(en_m);
            chk("gate on", shutdown_gate_o, 16'h0001);
            src(~en_m);
            chk("gate off", shutdown_gate_o, 16'h0000);
        end
        rdchk(`CCS_OFS_STATE, {en_m, 8'h00}, "gate enables");
        foreach (cs[j]) begin
            wr(`CCS_OFS_CTRL, {13'h0000, cs[j]});
            @(posedge sys_clk_i) logic_cell_two_i <= cs[j][2] & cs[j][1];
            src((cs[j] == 3'h7) ? 8'hff : {5'h00, cs[j] == 3'h3, cs[j] == 3'h2, 1'b0});
            chk("capture source", capture_src_o, 16'(cs[j] != 3'h7));
            @(posedge sys_clk_i) logic_cell_two_i <= 1'b0;
            src(8'h00);
            chk("capture source low", capture_src_o, 16'h0000);
        end
        for (int c = 0; c < 4; c++) begin
            wr(`CCS_OFS_CTRL, 16'(c << 3));
            n0 = aux_n;
            pulse(0);
            tick(3);
            @(posedge sys_clk_i) compare_event_i <= 1'b1;
            @(posedge sys_clk_i) compare_event_i <= 1'b0;
            @(posedge sys_clk_i) mode_signal_i <= 1'b1;
            @(posedge sys_clk_i);
            @(posedge sys_clk_i) mode_signal_i <= 1'b0;
            tick(3);
            chk("aux cycles", 16'(aux_n - n0), 16'(aux_e[c]));
        end
        wr(`CCS_OFS_INT_CLR, 16'h0007);
        wr(`CCS_OFS_INT_EN, 16'h0007);
        rdchk(`CCS_OFS_INT_STAT, 16'h0000, "status cleared");
        // Level mode with the gate high leaves the flag clear before arming
        src(8'h80);
        wr(`CCS_OFS_CTRL, 16'h0080);
        src(8'h00);
        chk("disable flag set", capture_disable_flag_o, 16'h0001);
        rdchk(`CCS_OFS_INT_STAT, 16'h0002, "status disable");
        chk("irq raised", irq_o, 16'h0001);
        capt(0);
        wr(`CCS_OFS_INT_CLR, 16'h0002);
        chk("irq cleared", irq_o, 16'h0000);
        wr(`CCS_OFS_CTRL, 16'h0040);
        src(8'h80);
        chk("disable flag clear", capture_disable_flag_o, 16'h0000);
        capt(1);
        rdchk(`CCS_OFS_INT_STAT, 16'h0001, "status capture");
        wr(`CCS_OFS_INT_EN, 16'h0000);
        chk("irq masked", irq_o, 16'h0000);
        wr(`CCS_OFS_CTRL, 16'h0000);
        src(8'h00);
        capt(0);
        src(8'h80);
        capt(1);
        conclude;
    end
endmodule // test_ccp_output_steer_gate_ctrl
